// File: include/sfct_pkg.sv
package sfct_pkg;

	localparam int CLK_NS    = 10;
	localparam int T_CS_NS   = 250;
	localparam int CS_CYC    = (T_CS_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_PWR_MS  = 20;
	localparam int PWR_CYC   = T_PWR_MS * 1000000 / CLK_NS;
	localparam int T_BRBD_US = 1;
	localparam int BRBD_CYC  = (T_BRBD_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int T_XFR_US  = 250;
	localparam int XFR_CYC   = T_XFR_US * 1000 / CLK_NS;
	localparam int T_EP_MS   = 20;
	localparam int EP_CYC    = T_EP_MS * 1000000 / CLK_NS;
	localparam int T_P_MS    = 14;
	localparam int P_CYC     = T_P_MS * 1000000 / CLK_NS;
	localparam int T_PE_MS   = 8;
	localparam int PE_CYC    = T_PE_MS * 1000000 / CLK_NS;
	localparam int T_BE_MS   = 12;
	localparam int BE_CYC    = T_BE_MS * 1000000 / CLK_NS;
	localparam int LINK_HALF_CYC = 6;

	localparam logic [9:0]  PAGE_LAST = 10'h20f;
	localparam logic [3:0]  HDR_BYTES = 4'h4;
	localparam logic [3:0]  CAR_DUMMY = 4'h4;
	localparam logic [3:0]  BUF_DUMMY = 4'h1;
	localparam logic [23:0] ADDR_MASK = 24'h7fffff;
	localparam logic [6:0]  STAT_LO_RST = 7'h00;

	localparam logic [7:0] OP_CAR_IPL = 8'h68;
	localparam logic [7:0] OP_CAR_SPI = 8'he8;
	localparam logic [7:0] OP_PRD_IPL = 8'h52;
	localparam logic [7:0] OP_PRD_SPI = 8'hd2;
	localparam logic [7:0] OP_BF1_IPL = 8'h54;
	localparam logic [7:0] OP_BF2_IPL = 8'h56;
	localparam logic [7:0] OP_BF1_SPI = 8'hd4;
	localparam logic [7:0] OP_BF2_SPI = 8'hd6;
	localparam logic [7:0] OP_ST_IPL  = 8'h57;
	localparam logic [7:0] OP_ST_SPI  = 8'hd7;
	localparam logic [7:0] OP_XFR1    = 8'h53;
	localparam logic [7:0] OP_XFR2    = 8'h55;
	localparam logic [7:0] OP_CMP1    = 8'h60;
	localparam logic [7:0] OP_CMP2    = 8'h61;
	localparam logic [7:0] OP_EPG1    = 8'h83;
	localparam logic [7:0] OP_EPG2    = 8'h86;
	localparam logic [7:0] OP_MPG1    = 8'h82;
	localparam logic [7:0] OP_MPG2    = 8'h85;
	localparam logic [7:0] OP_RWR1    = 8'h58;
	localparam logic [7:0] OP_RWR2    = 8'h59;
	localparam logic [7:0] OP_PG1     = 8'h88;
	localparam logic [7:0] OP_PG2     = 8'h89;
	localparam logic [7:0] OP_PER     = 8'h81;
	localparam logic [7:0] OP_BER     = 8'h50;

endpackage : sfct_pkg

// File: include/sfct_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sfct_if;
	logic sck;
	logic cs_n;
	logic si;
	logic so;
	logic rdy;
	logic rst_n;

	modport dev
	(
		input  sck,
		input  cs_n,
		input  si,
		input  rst_n,
		output so,
		output rdy
	);

	modport host
	(
		output sck,
		output cs_n,
		output si,
		output rst_n,
		input  so,
		input  rdy
	);
endinterface : sfct_if
`default_nettype wire

// File: hw/sfct_dev.sv
`timescale 1ns/1ps
`default_nettype none
module sfct_dev
#(
	parameter logic [6:0] STAT_LO = sfct_pkg::STAT_LO_RST,
	parameter int         XFR_CYC = sfct_pkg::XFR_CYC,
	parameter int         EP_CYC  = sfct_pkg::EP_CYC,
	parameter int         P_CYC   = sfct_pkg::P_CYC,
	parameter int         PE_CYC  = sfct_pkg::PE_CYC,
	parameter int         BE_CYC  = sfct_pkg::BE_CYC
)
(
	input  wire logic        CLOCK_I,
	input  wire logic        RST_I,
	input  wire logic [7:0]  RD_DATA_I,
	output logic      [7:0]  CMD_O,
	output logic      [23:0] ADDR_O,
	output logic             HDR_VALID_O,
	output logic      [7:0]  RX_DATA_O,
	output logic             RX_VALID_O,
	output logic             RD_REQ_O,
	output logic             CPOL_O,
	output logic             BUSY_O,
	sfct_if.dev              LNK
);

	function automatic logic is_stat(input logic [7:0] op);
		is_stat = (op == sfct_pkg::OP_ST_IPL) || (op == sfct_pkg::OP_ST_SPI);
	endfunction : is_stat

	function automatic logic [3:0] dummy_of(input logic [7:0] op);
		case (op)
			sfct_pkg::OP_CAR_IPL,
			sfct_pkg::OP_CAR_SPI,
			sfct_pkg::OP_PRD_IPL,
			sfct_pkg::OP_PRD_SPI: dummy_of = sfct_pkg::CAR_DUMMY;
			sfct_pkg::OP_BF1_IPL,
			sfct_pkg::OP_BF2_IPL,
			sfct_pkg::OP_BF1_SPI,
			sfct_pkg::OP_BF2_SPI: dummy_of = sfct_pkg::BUF_DUMMY;
			default: dummy_of = 4'h0;
		endcase
	endfunction : dummy_of

	function automatic logic [31:0] op_cyc(input logic [7:0] op);
		case (op)
			sfct_pkg::OP_XFR1,
			sfct_pkg::OP_XFR2,
			sfct_pkg::OP_CMP1,
			sfct_pkg::OP_CMP2: op_cyc = 32'(XFR_CYC);
			sfct_pkg::OP_EPG1,
			sfct_pkg::OP_EPG2,
			sfct_pkg::OP_MPG1,
			sfct_pkg::OP_MPG2,
			sfct_pkg::OP_RWR1,
			sfct_pkg::OP_RWR2: op_cyc = 32'(EP_CYC);
			sfct_pkg::OP_PG1,
			sfct_pkg::OP_PG2: op_cyc = 32'(P_CYC);
			sfct_pkg::OP_PER: op_cyc = 32'(PE_CYC);
			sfct_pkg::OP_BER: op_cyc = 32'(BE_CYC);
			default: op_cyc = 32'h0;
		endcase
	endfunction : op_cyc

	logic [2:0]  sck_s;
	logic [2:0]  cs_s;
	logic [1:0]  si_s;
	logic [1:0]  rn_s;
	logic        prot_rst;
	logic        sel;
	logic        sck_rise;
	logic        sck_fall;
	logic        cs_fall;
	logic        cs_rise;
	logic        cpol_q;
	logic [2:0]  bit_q;
	logic [3:0]  cnt_q;
	logic [7:0]  sh_q;
	logic [7:0]  cmd_q;
	logic [23:0] addr_q;
	logic        hdr_vld_q;
	logic [7:0]  rx_q;
	logic        rx_vld_q;
	logic [7:0]  byte_w;
	logic        data_ph;
	logic [7:0]  tx_q;
	logic [7:0]  ld_w;
	logic        so_q;
	logic        rd_req_q;
	logic [31:0] busy_q;
	logic [31:0] busy_d;
	logic        start_w;
	logic        rdy_q;

	// Pins arrive from the host's clock domain and pass two flops first.
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			sck_s <= 3'h0;
			cs_s  <= 3'h7;
			si_s  <= 2'h0;
			rn_s  <= 2'h0;
		end
		else
		begin
			sck_s <= {sck_s[1:0], LNK.sck};
			cs_s  <= {cs_s[1:0], LNK.cs_n};
			si_s  <= {si_s[0], LNK.si};
			rn_s  <= {rn_s[0], LNK.rst_n};
		end
	end

	// The pin reset clears the protocol; a select held high across its
	// release guarantees no half command survives.
	assign prot_rst = RST_I | ~rn_s[1];
	assign sel      = ~cs_s[1];
	assign sck_rise = sck_s[1] & ~sck_s[2];
	assign sck_fall = ~sck_s[1] & sck_s[2];
	assign cs_fall  = ~cs_s[1] & cs_s[2];
	assign cs_rise  = cs_s[1] & ~cs_s[2];
	assign byte_w   = {sh_q[6:0], si_s[1]};

	// The clock level at select fall tells which convention is in use.
	always_ff @(posedge CLOCK_I)
	begin
		if (prot_rst)
			cpol_q <= 1'b0;
		else if (cs_fall)
			cpol_q <= sck_s[1];
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (prot_rst)
		begin
			bit_q     <= 3'h0;
			cnt_q     <= 4'h0;
			sh_q      <= 8'h00;
			cmd_q     <= 8'h00;
			addr_q    <= 24'h000000;
			hdr_vld_q <= 1'b0;
			rx_q      <= 8'h00;
			rx_vld_q  <= 1'b0;
		end
		else
		begin
			hdr_vld_q <= 1'b0;
			rx_vld_q  <= 1'b0;
			if (cs_fall)
			begin
				bit_q <= 3'h0;
				cnt_q <= 4'h0;
			end
			else if (sel && sck_rise)
			begin
				sh_q  <= byte_w;
				bit_q <= bit_q + 3'h1;
				if (bit_q == 3'h7)
				begin
					if (cnt_q != 4'hf)
						cnt_q <= cnt_q + 4'h1;
					if (cnt_q == 4'h0)
						cmd_q <= byte_w;
					else if (cnt_q < sfct_pkg::HDR_BYTES)
						addr_q <= {addr_q[15:0], byte_w};
					if ((cnt_q == 4'h3) || ((cnt_q == 4'h0) && is_stat(byte_w)))
						hdr_vld_q <= 1'b1;
					if ((cnt_q >= sfct_pkg::HDR_BYTES) && !is_stat(cmd_q)
						&& (dummy_of(cmd_q) == 4'h0))
					begin
						rx_q     <= byte_w;
						rx_vld_q <= 1'b1;
					end
				end
			end
		end
	end

	// Read opcodes of both naming sets are accepted in every convention,
	// since idle-low and mode 0 cannot be told apart on the pins.
	assign data_ph = is_stat(cmd_q) ? (cnt_q != 4'h0) :
		((dummy_of(cmd_q) != 4'h0) &&
		(cnt_q >= (sfct_pkg::HDR_BYTES + dummy_of(cmd_q))));

	// Status repeats for as long as the host clocks; later bytes carry
	// the live ready flag in bit 7 over the fixed STAT_LO bits, as the first does.
	assign ld_w = is_stat(cmd_q) ? {rdy_q, STAT_LO} : RD_DATA_I;

	// Output bits change on the falling edge so the host may sample on
	// the rising one in both modes.
	always_ff @(posedge CLOCK_I)
	begin
		if (prot_rst)
		begin
			tx_q     <= 8'h00;
			so_q     <= 1'b0;
			rd_req_q <= 1'b0;
		end
		else
		begin
			rd_req_q <= 1'b0;
			if (sel && sck_fall && data_ph)
			begin
				if (bit_q == 3'h0)
				begin
					so_q     <= ld_w[7];
					tx_q     <= {ld_w[6:0], 1'b0};
					rd_req_q <= ~is_stat(cmd_q);
				end
				else
				begin
					so_q <= tx_q[7];
					tx_q <= {tx_q[6:0], 1'b0};
				end
			end
		end
	end

	// A complete header followed by select rise launches the timer; a
	// command arriving while busy is not started.
	assign start_w = cs_rise && (bit_q == 3'h0) &&
		(cnt_q >= sfct_pkg::HDR_BYTES) && (busy_q == 32'h0) &&
		(op_cyc(cmd_q) != 32'h0);

	always_comb
	begin
		if (start_w)
			busy_d = op_cyc(cmd_q);
		else if (busy_q != 32'h0)
			busy_d = busy_q - 32'h1;
		else
			busy_d = 32'h0;
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (prot_rst)
		begin
			busy_q <= 32'h0;
			rdy_q  <= 1'b1;
		end
		else
		begin
			busy_q <= busy_d;
			rdy_q  <= (busy_d == 32'h0);
		end
	end

	assign LNK.so      = so_q;
	assign LNK.rdy     = rdy_q;
	assign CMD_O       = cmd_q;
	assign ADDR_O      = addr_q;
	assign HDR_VALID_O = hdr_vld_q;
	assign RX_DATA_O   = rx_q;
	assign RX_VALID_O  = rx_vld_q;
	assign RD_REQ_O    = rd_req_q;
	assign CPOL_O      = cpol_q;
	assign BUSY_O      = ~rdy_q;

endmodule : sfct_dev
`default_nettype wire

// File: hw/sfct_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfct_host
#(
	parameter bit CPOL     = 1'b0,
	parameter int HALF_CYC = sfct_pkg::LINK_HALF_CYC,
	parameter int PWR_CYC  = sfct_pkg::PWR_CYC
)
(
	input  wire logic        CLOCK_I,
	input  wire logic        RST_I,
	input  wire logic        START_I,
	input  wire logic [7:0]  OPCODE_I,
	input  wire logic [23:0] ADDR_I,
	input  wire logic [3:0]  DUMMY_I,
	input  wire logic [15:0] LEN_I,
	input  wire logic        BURST_I,
	input  wire logic [7:0]  WR_DATA_I,
	output logic             READY_O,
	output logic             WR_REQ_O,
	output logic      [7:0]  RX_DATA_O,
	output logic             RX_VALID_O,
	output logic             DONE_O,
	output logic             FLASH_RDY_O,
	sfct_if.host             LNK
);

	typedef enum logic [6:0]
	{
		H_PWR   = 7'h01,
		H_IDLE  = 7'h02,
		H_LEAD  = 7'h04,
		H_SHIFT = 7'h08,
		H_PAUSE = 7'h10,
		H_TAIL  = 7'h20,
		H_GAP   = 7'h40
	} sfct_hst_e;

	sfct_hst_e   st_q;
	logic [31:0] tmr_q;
	logic [7:0]  div_q;
	logic        ph_q;
	logic [2:0]  bit_q;
	logic [15:0] byte_q;
	logic [15:0] last_q;
	logic [15:0] ds_q;
	logic [9:0]  page_q;
	logic        burst_q;
	logic [7:0]  op_q;
	logic [23:0] addr_q;
	logic [7:0]  tx_q;
	logic [7:0]  rsh_q;
	logic [1:0]  so_s;
	logic [1:0]  rdy_s;
	logic        sck_q;
	logic        cs_n_q;
	logic        si_q;
	logic        rst_n_q;
	logic        wr_req_q;
	logic [7:0]  rx_q;
	logic        rx_vld_q;
	logic        done_q;
	logic [15:0] hdr_w;
	logic [7:0]  nxt_w;

	function automatic logic [7:0] nb(input logic [15:0] i);
		if (i == 16'h0)
			nb = op_q;
		else if (i < 16'(sfct_pkg::HDR_BYTES) && (ds_q != 16'h1))
			nb = addr_q[8'(23 - 8 * (i - 16'h1)) -: 8];
		else if (i < ds_q)
			nb = 8'h00;
		else
			nb = WR_DATA_I;
	endfunction : nb

	assign hdr_w = ((OPCODE_I == sfct_pkg::OP_ST_IPL) ||
		(OPCODE_I == sfct_pkg::OP_ST_SPI)) ? 16'h1 :
		16'(sfct_pkg::HDR_BYTES) + 16'(DUMMY_I);

	// A process rather than an assign, so that changes of the registers
	// read inside the function are seen as well as its argument.
	always_comb
	begin
		nxt_w = nb(byte_q + 16'h1);
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			so_s  <= 2'h0;
			rdy_s <= 2'h0;
		end
		else
		begin
			so_s  <= {so_s[0], LNK.so};
			rdy_s <= {rdy_s[0], LNK.rdy};
		end
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			st_q     <= H_PWR;
			tmr_q    <= 32'h0;
			div_q    <= 8'h00;
			ph_q     <= 1'b0;
			bit_q    <= 3'h0;
			byte_q   <= 16'h0;
			last_q   <= 16'h0;
			ds_q     <= 16'h0;
			page_q   <= 10'h000;
			burst_q  <= 1'b0;
			op_q     <= 8'h00;
			addr_q   <= 24'h000000;
			tx_q     <= 8'h00;
			rsh_q    <= 8'h00;
			sck_q    <= CPOL;
			cs_n_q   <= 1'b1;
			si_q     <= 1'b0;
			rst_n_q  <= 1'b0;
			wr_req_q <= 1'b0;
			rx_q     <= 8'h00;
			rx_vld_q <= 1'b0;
			done_q   <= 1'b0;
		end
		else
		begin
			rst_n_q  <= 1'b1;
			wr_req_q <= 1'b0;
			rx_vld_q <= 1'b0;
			done_q   <= 1'b0;
			tmr_q    <= tmr_q + 32'h1;
			case (st_q)
				H_PWR:
					if (tmr_q == 32'(PWR_CYC - 1))
						st_q <= H_IDLE;
				H_IDLE:
				begin
					tmr_q <= 32'h0;
					if (START_I)
					begin
						op_q    <= OPCODE_I;
						addr_q  <= ADDR_I & sfct_pkg::ADDR_MASK;
						ds_q    <= hdr_w;
						last_q  <= hdr_w + LEN_I - 16'h1;
						page_q  <= ADDR_I[9:0];
						burst_q <= BURST_I;
						byte_q  <= 16'h0;
						cs_n_q  <= 1'b0;
						st_q    <= H_LEAD;
					end
				end
				H_LEAD:
					if (tmr_q == 32'(sfct_pkg::CS_CYC - 1))
					begin
						tx_q  <= {op_q[6:0], 1'b0};
						si_q  <= op_q[7];
						sck_q <= 1'b0;
						div_q <= 8'h00;
						ph_q  <= 1'b0;
						bit_q <= 3'h0;
						st_q  <= H_SHIFT;
					end
				H_SHIFT:
					if (div_q != 8'(HALF_CYC - 1))
						div_q <= div_q + 8'h1;
					else if (!ph_q)
					begin
						div_q <= 8'h00;
						ph_q  <= 1'b1;
						sck_q <= 1'b1;
					end
					else
					begin
						div_q <= 8'h00;
						ph_q  <= 1'b0;
						sck_q <= 1'b0;
						tmr_q <= 32'h0;
						rsh_q <= {rsh_q[6:0], so_s[1]};
						bit_q <= bit_q + 3'h1;
						si_q  <= tx_q[7];
						tx_q  <= {tx_q[6:0], 1'b0};
						if (bit_q == 3'h7)
						begin
							byte_q <= byte_q + 16'h1;
							si_q   <= nxt_w[7];
							tx_q   <= {nxt_w[6:0], 1'b0};
							wr_req_q <= (byte_q + 16'h1 >= ds_q) &&
								(byte_q != last_q);
							if (byte_q >= ds_q)
							begin
								rx_q     <= {rsh_q[6:0], so_s[1]};
								rx_vld_q <= 1'b1;
								page_q   <= (page_q == sfct_pkg::PAGE_LAST) ?
									10'h000 : page_q + 10'h001;
							end
							if (byte_q == last_q)
							begin
								sck_q <= CPOL;
								st_q  <= H_TAIL;
							end
							else if (burst_q && (byte_q >= ds_q) &&
								(page_q == sfct_pkg::PAGE_LAST))
							begin
								sck_q <= CPOL;
								st_q  <= H_PAUSE;
							end
						end
					end
				H_PAUSE:
					if (tmr_q == 32'(sfct_pkg::BRBD_CYC - 1))
					begin
						sck_q <= 1'b0;
						div_q <= 8'h00;
						st_q  <= H_SHIFT;
					end
				H_TAIL:
					if (tmr_q == 32'(sfct_pkg::CS_CYC - 1))
					begin
						cs_n_q <= 1'b1;
						tmr_q  <= 32'h0;
						st_q   <= H_GAP;
					end
				H_GAP:
					if (tmr_q == 32'(sfct_pkg::CS_CYC - 1))
					begin
						done_q <= 1'b1;
						st_q   <= H_IDLE;
					end
				default:
					st_q <= H_PWR;
			endcase
		end
	end

	assign LNK.sck     = sck_q;
	assign LNK.cs_n    = cs_n_q;
	assign LNK.si      = si_q;
	assign LNK.rst_n   = rst_n_q;
	assign READY_O     = (st_q == H_IDLE);
	assign WR_REQ_O    = wr_req_q;
	assign RX_DATA_O   = rx_q;
	assign RX_VALID_O  = rx_vld_q;
	assign DONE_O      = done_q;
	assign FLASH_RDY_O = rdy_s[1];

endmodule : sfct_host
`default_nettype wire

// File: verif/sfct_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sfct_properties
#(
	parameter int EP_CYC  = sfct_pkg::EP_CYC,
	parameter int XFR_CYC = sfct_pkg::XFR_CYC
)
(
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic so,
	input wire logic rdy,
	input wire logic rst_n
);
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (RST_I);

	// The gap count starts saturated, so the first frame after reset is
	// not taken for a short gap.
	logic [5:0]  gap_q;
	logic [31:0] busy_q;
	logic [2:0]  bit_q;
	logic        sck_q;

	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
			gap_q <= 6'h3f;
		else if (!cs_n)
			gap_q <= 6'h00;
		else if (gap_q != 6'h3f)
			gap_q <= gap_q + 6'h01;
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I || rdy)
			busy_q <= 32'h0;
		else
			busy_q <= busy_q + 32'h1;
	end

	always_ff @(posedge CLOCK_I)
	begin
		sck_q <= sck;
		if (RST_I || cs_n)
			bit_q <= 3'h0;
		else if (sck && !sck_q)
			bit_q <= bit_q + 3'h1;
	end

	sequence s_si_hold;
		$stable(si) ##1 $stable(si);
	endsequence

	property p_gap;
		$fell(cs_n) |-> gap_q >= sfct_pkg::CS_CYC;
	endproperty
	a_gap: assert property (p_gap)
		else $error("select gap too short");
	property p_rst;
		!rst_n |-> cs_n;
	endproperty
	a_rst: assert property (p_rst)
		else $error("select low while reset held");
	property p_busy_fast;
		$fell(rdy) |-> cs_n && gap_q <= 6'h14;
	endproperty
	a_busy_fast: assert property (p_busy_fast)
		else $error("busy not within 200 ns of select rise");
	property p_busy_max;
		!rdy |-> busy_q < EP_CYC;
	endproperty
	a_busy_max: assert property (p_busy_max)
		else $error("busy longer than longest operation");
	property p_busy_min;
		$rose(rdy) |-> busy_q >= XFR_CYC;
	endproperty
	a_busy_min: assert property (p_busy_min)
		else $error("ready returned before operation end");
	property p_bytes;
		$rose(cs_n) |-> bit_q == 3'h0;
	endproperty
	a_bytes: assert property (p_bytes)
		else $error("frame not whole bytes");
	property p_idle;
		cs_n && $past(cs_n) |-> $stable(sck);
	endproperty
	a_idle: assert property (p_idle)
		else $error("serial clock moved while deselected");
	property p_si_hold;
		$rose(sck) && !cs_n |-> s_si_hold;
	endproperty
	a_si_hold: assert property (p_si_hold)
		else $error("input data moved at rising clock");
	property p_so_hold;
		$rose(sck) && !cs_n |-> $stable(so) [*5];
	endproperty
	a_so_hold: assert property (p_so_hold)
		else $error("output data moved in clock high phase");
endmodule : sfct_properties
`default_nettype wire

// File: verif/serial_flash_command_timing_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_timing_test;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        start = 1'b0;
	logic [7:0]  op = 8'h00;
	logic [23:0] adr = 24'h0;
	logic [3:0]  dum = 4'h0;
	logic [15:0] len = 16'h1;
	logic [1:0]  mode = 2'h0;
	logic        burst = 1'b0;
	logic [1:0]  sck_p;
	logic [7:0]  rd [2] = '{8'h3c, 8'h3c};
	logic [7:0]  wr [2] = '{8'hc0, 8'hc0};
	logic [7:0]  rexp [2];
	logic [7:0]  wexp [2];
	wire logic [1:0]  rdy_o, hrv, drv, wrq, rrq, bsy, cpol;
	wire logic [1:0]  hdv, dno, frdy, sck_w, csn_w;
	wire logic [7:0]  hrx [2], drx [2], cmd [2];
	wire logic [23:0] dadr [2];
	int          err_count = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          rxn [2], drxn [2], bz [2];
	int          hdn [2], qmax [2], quiet [2] = '{0, 0};

	// Short operation times keep the whole run within a few ten thousand
	// cycles while every timer still runs to its end.
	localparam int XFR = 50;
	localparam int EP  = 2000;
	localparam int PRG = 150;
	localparam int PER = 80;
	localparam int BER = 120;
	localparam int PWR = 20;

	always #5 clk = ~clk;

	for (genvar g = 0; g < 2; g++)
	begin : p
		sfct_if lnk ();
		sfct_dev #(.XFR_CYC(XFR), .EP_CYC(EP), .P_CYC(PRG), .PE_CYC(PER),
			.BE_CYC(BER)) sfct_dev_i (.CLOCK_I(clk), .RST_I(rst),
			.RD_DATA_I(rd[g]), .CMD_O(cmd[g]), .ADDR_O(dadr[g]),
			.HDR_VALID_O(hdv[g]), .RX_DATA_O(drx[g]), .RX_VALID_O(drv[g]),
			.RD_REQ_O(rrq[g]), .CPOL_O(cpol[g]), .BUSY_O(bsy[g]),
			.LNK(lnk));
		sfct_host #(.CPOL(g == 1), .PWR_CYC(PWR)) sfct_host_i (.CLOCK_I(clk),
			.RST_I(rst), .START_I(start), .OPCODE_I(op), .ADDR_I(adr),
			.DUMMY_I(dum), .LEN_I(len), .BURST_I(burst), .WR_DATA_I(wr[g]),
			.READY_O(rdy_o[g]), .WR_REQ_O(wrq[g]), .RX_DATA_O(hrx[g]),
			.RX_VALID_O(hrv[g]), .DONE_O(dno[g]), .FLASH_RDY_O(frdy[g]),
			.LNK(lnk));
		assign sck_w[g] = lnk.sck;
		assign csn_w[g] = lnk.cs_n;
		if (g == 0)
		begin : c
			sfct_properties #(.EP_CYC(EP), .XFR_CYC(XFR)) sfct_properties_i
				(.CLOCK_I(clk), .RST_I(rst), .sck(lnk.sck), .cs_n(lnk.cs_n),
				.si(lnk.si), .so(lnk.so), .rdy(lnk.rdy), .rst_n(lnk.rst_n));
		end
	end

	task automatic finish_test();
		if (err_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		comparisons++;
		if (e !== s)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		for (int i = 0; i < 2; i++)
		begin
			if (rrq[i] === 1'b1)
				rd[i] <= rd[i] + 8'h01;
			if (wrq[i] === 1'b1)
				wr[i] <= wr[i] + 8'h01;
			if (bsy[i] === 1'b1)
				bz[i] <= bz[i] + 1;
			if (hdv[i] === 1'b1)
				hdn[i] <= hdn[i] + 1;
			// Longest stretch without a clock edge while selected.
			if (csn_w[i] !== 1'b0 || sck_w[i] !== sck_p[i])
				quiet[i] <= 0;
			else
				quiet[i] <= quiet[i] + 1;
			if (quiet[i] > qmax[i])
				qmax[i] <= quiet[i];
			if (hrv[i] === 1'b1 && mode == 2'h1)
			begin
				chk("host byte", rexp[i], hrx[i]);
				rexp[i] <= rexp[i] + 8'h01;
				rxn[i] <= rxn[i] + 1;
			end
			if (drv[i] === 1'b1 && mode == 2'h2)
			begin
				chk("device byte", wexp[i], drx[i]);
				wexp[i] <= wexp[i] + 8'h01;
				drxn[i] <= drxn[i] + 1;
			end
		end
		sck_p <= sck_w;
		// Generous ceiling: the full run needs well under half of it.
		if (cyc == 60000)
		begin
			err_count++;
			finish_test();
		end
	end

	task automatic xfer(input logic [7:0] o, input logic [23:0] a,
		input logic [3:0] d, input logic [15:0] n);
		int t;
		t = 0;
		while (rdy_o !== 2'b11 && t < 3000)
		begin
			@(negedge clk);
			t++;
		end
		@(posedge clk);
		op <= o;
		adr <= a;
		dum <= d;
		len <= n;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		t = 0;
		do
		begin
			@(negedge clk);
			t++;
		end
		while (rdy_o !== 2'b11 && t < 3000);
		chk("transfer end", 1, t < 3000);
		chk("done pulse", 2'b11, dno);
	endtask : xfer

	task automatic t_status();
		logic [7:0] ops [2] = '{8'h57, 8'hd7};
		foreach (ops[k])
		begin
			mode = 2'h1;
			rexp = '{8'h80, 8'h80};
			rxn = '{0, 0};
			hdn = '{0, 0};
			xfer(ops[k], 24'h0, 4'h0, 16'h1);
			for (int i = 0; i < 2; i++)
			begin
				chk("status count", 1, rxn[i]);
				chk("status header", 1, hdn[i]);
				chk("status opcode", ops[k], cmd[i]);
				chk("clock level", i, cpol[i]);
			end
		end
	endtask : t_status

	task automatic t_reads();
		logic [7:0]  ops [8] = '{8'h68, 8'he8, 8'h52, 8'hd2,
			8'h54, 8'h56, 8'hd4, 8'hd6};
		logic [3:0]  dm;
		logic [23:0] a;
		foreach (ops[k])
		begin
			dm = (k < 4) ? sfct_pkg::CAR_DUMMY : sfct_pkg::BUF_DUMMY;
			a = 24'h80020f ^ 24'(k);
			mode = 2'h1;
			rexp = rd;
			rxn = '{0, 0};
			hdn = '{0, 0};
			qmax = '{0, 0};
			xfer(ops[k], a, dm, 16'h2);
			for (int i = 0; i < 2; i++)
			begin
				chk("read count", 2, rxn[i]);
				chk("read header", 1, hdn[i]);
				chk("no pause", 1, qmax[i] < sfct_pkg::BRBD_CYC);
				chk("read opcode", ops[k], cmd[i]);
				chk("address", a & sfct_pkg::ADDR_MASK, dadr[i]);
			end
		end
	endtask : t_reads

	// The second data byte lands on the last page offset, so the clock
	// must stop before the third.
	task automatic t_burst();
		mode = 2'h1;
		rexp = rd;
		rxn = '{0, 0};
		qmax = '{0, 0};
		@(posedge clk);
		burst <= 1'b1;
		xfer(sfct_pkg::OP_CAR_IPL, 24'h00020e, sfct_pkg::CAR_DUMMY, 16'h3);
		@(posedge clk);
		burst <= 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			chk("burst count", 3, rxn[i]);
			chk("burst pause", 1, qmax[i] >= sfct_pkg::BRBD_CYC);
		end
	endtask : t_burst

	task automatic t_write();
		mode = 2'h2;
		wexp = wr;
		drxn = '{0, 0};
		xfer(8'h84, 24'h000005, 4'h0, 16'h3);
		for (int i = 0; i < 2; i++)
		begin
			chk("write count", 3, drxn[i]);
			chk("no busy", 0, bsy[i]);
		end
	endtask : t_write

	task automatic t_busy();
		logic [7:0] ops [10] = '{8'h83, 8'h53, 8'h60, 8'h88, 8'h81, 8'h50,
			8'h55, 8'h61, 8'h89, 8'h58};
		int         cy [10] = '{EP, XFR, XFR, PRG, PER, BER,
			XFR, XFR, PRG, EP};
		int         t;
		foreach (ops[k])
		begin
			mode = 2'h0;
			bz = '{0, 0};
			xfer(ops[k], 24'h001000, 4'h0, 16'h1);
			// A second operation while busy must neither start nor stretch.
			if (k == 0)
				xfer(8'h53, 24'h002000, 4'h0, 16'h1);
			chk("host sees busy", 0, frdy);
			t = 0;
			while (bsy !== 2'b00 && t < 2500)
			begin
				@(negedge clk);
				t++;
			end
			for (int i = 0; i < 2; i++)
				chk("busy cycles", cy[k], bz[i]);
		end
	endtask : t_busy

	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(negedge clk);
		chk("ready in power wait", 0, rdy_o);
		t_status();
		t_reads();
		t_burst();
		t_write();
		t_busy();
		finish_test();
	end
endmodule : serial_flash_command_timing_test
`default_nettype wire
